// [sim/dcs_engine_model.sv]
// Transfer engine stand-in: one-cycle event pulses into the block.
// Assumes calls right after a rising CORE_CLK edge.
`timescale 1ns/1ns
module dcs_engine_model (
    // Clock
    input  wire logic              CORE_CLK,
    // Event pulses
    output logic                   XFER_DONE,
    output logic                   BLOCK_DONE,
    output dcs_pkg::dcs_chan_id_t  XFER_CHAN,
    output dcs_pkg::dcs_half_t     XFER_RAM_ADDR,
    output dcs_pkg::dcs_chan_vec_t PERIPH_COLLISION,
    output dcs_pkg::dcs_chan_vec_t RAM_COLLISION
);
    import dcs_pkg::*;
    // Quiet at start, qualifiers not left at a usable value
    initial {XFER_DONE, BLOCK_DONE, PERIPH_COLLISION, RAM_COLLISION, XFER_CHAN, XFER_RAM_ADDR} = {18'h0, 19'h7FFFF};
    // One transfer ending a block, with optional collisions
    task automatic ev(input dcs_chan_id_t ch, input dcs_half_t ra, input dcs_chan_vec_t pc, rc);
        {XFER_DONE, BLOCK_DONE, XFER_CHAN, XFER_RAM_ADDR, PERIPH_COLLISION, RAM_COLLISION} <= {2'b11, ch, ra, pc, rc};
        @(posedge CORE_CLK);
        {XFER_DONE, BLOCK_DONE, XFER_CHAN, XFER_RAM_ADDR, PERIPH_COLLISION, RAM_COLLISION} <= {2'b00, ~ch, ~ra, 16'h0};
    endtask
endmodule // dcs_engine_model

// [sim/dcs_top_sva.sv]
// Checker on the ports of the count/status block.
// Assumes binding onto dcs_top with matching port names.
`timescale 1ns/1ns
module dcs_top_chk (
    // Clock, reset, enable
    input wire logic                   CORE_CLK,
    input wire logic                   RST,
    input wire logic                   CLK_EN,
    // Bus
    input wire logic [1:0]             HTRANS,
    input wire logic                   HWRITE,
    input wire logic [31:0]            HRDATA,
    input wire logic                   HREADYOUT,
    input wire logic                   HRESP,
    // Engine side
    input wire dcs_pkg::dcs_chan_id_t  XFER_CHAN,
    input wire logic                   BLOCK_DONE,
    input wire dcs_pkg::dcs_chan_vec_t PINGPONG_MODE,
    input wire dcs_pkg::dcs_chan_vec_t CHAN_ACTIVE,
    input wire dcs_pkg::dcs_chan_vec_t PINGPONG_SEL,
    input wire logic [127:0]           CHAN_PERIPH_ADDR,
    input wire logic [79:0]            CHAN_XFER_COUNT
);
    import dcs_pkg::*;
    // All checks on the core clock
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not okay");
    a_rdata_upper: assert property (HRDATA[31:16] == 16'h0000) else $error("upper half set");
    a_reset_vals: assert property ($fell(RST) |-> CHAN_PERIPH_ADDR == 0 && CHAN_XFER_COUNT == 0
        && PINGPONG_SEL == 0) else $error("bad reset value");
    a_cfg_write: assert property ($changed({CHAN_PERIPH_ADDR, CHAN_XFER_COUNT})
        |-> $past(HTRANS[1] && HWRITE && CLK_EN, 2)) else $error("config moved without write");
    a_active_write: assert property ($changed(CHAN_ACTIVE) |-> $past(HTRANS[1] && HWRITE, 2))
        else $error("enable moved without write");
    a_pp_toggle: assert property (BLOCK_DONE && CLK_EN && PINGPONG_MODE[XFER_CHAN] && CHAN_ACTIVE[XFER_CHAN]
        |=> (PINGPONG_SEL ^ $past(PINGPONG_SEL)) == (8'h01 << $past(XFER_CHAN))) else $error("no toggle");
    a_pp_hold: assert property (!(BLOCK_DONE && PINGPONG_MODE[XFER_CHAN]) |=> $stable(PINGPONG_SEL))
        else $error("select moved");
    a_pp_disabled: assert property (BLOCK_DONE && !CHAN_ACTIVE[XFER_CHAN] |=> $stable(PINGPONG_SEL))
        else $error("idle channel toggled");
endmodule // dcs_top_chk
bind dcs_top dcs_top_chk chk (.*);

// [sim/dma_channel_count_status_regs_tb_top.sv]
// Bench: AHB-Lite register tasks and engine events against expected values.
// Assumes dcs_top, the engine model and the bound checker.
`timescale 1ns/1ns
module dma_channel_count_status_regs_tb_top;
    import dcs_pkg::*;
    logic CORE_CLK = 1'b0, RST = 1'b1, CLK_EN = 1'b1, HSEL = 1'b1, HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [1:0] HTRANS = 2'h0;
    logic [11:0] HADDR = 12'h000, pa, ca;
    logic [31:0] HWDATA = 32'h0, HRDATA, rd_q;
    logic HREADYOUT, HRESP, XFER_DONE, BLOCK_DONE, IRQ;
    wire logic HREADY = HREADYOUT;
    dcs_chan_id_t XFER_CHAN;
    dcs_half_t XFER_RAM_ADDR;
    dcs_chan_vec_t PINGPONG_MODE = 8'h0C, PERIPH_COLLISION, RAM_COLLISION, CHAN_ACTIVE, PINGPONG_SEL;
    logic [127:0] CHAN_PERIPH_ADDR;
    logic [79:0] CHAN_XFER_COUNT;
    int bad_count = 0, check_count = 0, cyc = 0;
    dcs_top uut (.*);
    dcs_engine_model eng (.*);
    // Clock and hang guard
    initial forever #2 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            $display("mismatch at %0t: hang", $time);
            print_verdict();
        end
    end
    // One single transfer; read data taken at the data-phase edge, then one idle cycle
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        {HTRANS, HADDR, HWRITE} <= {2'h2, a, w};
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
        {HTRANS, HWDATA} <= {2'h0, d};
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
        rd_q = HRDATA;
        @(posedge CORE_CLK);
    endtask
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        rc(12'h004, 32'h0000_0F00);
        rc(12'h008, 32'h0000_0000);
        for (int n = 0; n < 8; n++) begin
            pa = 12'h040 + 12'(4 * n);
            ca = 12'h080 + 12'(4 * n);
            rc(pa, 32'h0);
            rc(ca, 32'h0);
            bus(1'b1, pa, 32'hFFFF_C300 + 32'(n));
            bus(1'b1, ca, 32'hFFFF_FFFF - 32'(n));
            rc(pa, 32'h0000_C300 + 32'(n));
            rc(ca, 32'h0000_03FF - 32'(n));
            chk(32'(CHAN_XFER_COUNT[n * 10 +: 10]), 32'h0000_03FF - 32'(n));
            chk(32'(CHAN_PERIPH_ADDR[n * 16 +: 16]), 32'h0000_C300 + 32'(n));
        end
        bus(1'b1, 12'h020, 32'hFFFF_FFFF);
        rc(12'h020, 32'h0);
        bus(1'b1, 12'h014, 32'h0000_0024);
        chk(32'(CHAN_ACTIVE), 32'h0000_0024);
        eng.ev(3'd2, 16'h1234, 8'h00, 8'h00);
        rc(12'h004, 32'h0000_0204);
        chk(32'(PINGPONG_SEL), 32'h0000_0004);
        rc(12'h008, 32'h0000_1234);
        rc(12'h000, 32'h0);
        chk(32'(IRQ), 32'h0);
        bus(1'b1, 12'h010, 32'h0000_0004);
        eng.ev(3'd3, 16'h4321, 8'h81, 8'h02);
        rc(12'h000, 32'h0000_8102);
        chk(32'(IRQ), 32'h1);
        rc(12'h004, 32'h0000_0304);
        rc(12'h00C, 32'h0000_0007);
        chk(32'(IRQ), 32'h0);
        bus(1'b1, 12'h000, 32'h0000_7FFF);
        rc(12'h000, 32'h0000_0102);
        print_verdict();
    end
endmodule // dma_channel_count_status_regs_tb_top

// [verilog/dcs_defines.svh]
// Register map, field positions, reset values of the DMA channel count/status block.
// Assumes inclusion by the package and the top module only.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
`define DCS_NUM_CHAN        8
`define DCS_OFF_COLL        12'h000
`define DCS_OFF_ACT         12'h004
`define DCS_OFF_RAMADDR     12'h008
`define DCS_OFF_IRQ_STAT    12'h00C
`define DCS_OFF_IRQ_MASK    12'h010
`define DCS_OFF_CHAN_EN     12'h014
`define DCS_OFF_PAD_BASE    12'h040
`define DCS_OFF_CNT_BASE    12'h080
`define DCS_CNT_W           10
`define DCS_PERIPH_WRITE_COLLISION_LSB       8
`define DCS_RAM_WRITE_COLLISION_LSB       0
`define DCS_LAST_LSB        8
`define DCS_LAST_RESET      4'hF
`define DCS_RST_16          16'h0000
`define DCS_IRQ_W           3
`endif

// [verilog/dcs_pkg.sv]
// Types shared by the DMA channel count/status block.
// Assumes dcs_defines.svh on the include path.
`include "dcs_defines.svh"
package dcs_pkg;
    typedef logic [15:0] dcs_half_t;
    typedef logic [7:0]  dcs_chan_vec_t;
    typedef logic [2:0]  dcs_chan_id_t;
    typedef enum logic [1:0] {
        DCS_IDLE = 2'b00,
        DCS_DATA = 2'b01
    } dcs_phase_t;
    typedef struct packed {
        dcs_phase_t    phase;
        logic          wr;
        logic [11:0]   addr;
        logic [31:0]   rdata;
        dcs_half_t [7:0] pad;
        logic [7:0][9:0] cnt;
        dcs_chan_vec_t periph_write_collision;
        dcs_chan_vec_t ram_write_collision;
        logic [3:0]    last_chan;
        dcs_chan_vec_t pp_sel;
        dcs_half_t     ram_addr;
        dcs_chan_vec_t chan_en;
        logic [2:0]    irq_stat;
        logic [2:0]    irq_mask;
    } dcs_state_t;
endpackage

// [verilog/dcs_top.sv]
// AHB-Lite slave holding per-channel peripheral address and transfer count
// registers, plus collision, activity, ping-pong and recent-RAM-address status.
// Assumes a transfer engine on CORE_CLK reports its events as one-cycle pulses.
// Functional notes
// - Every channel has a 16-bit read/write peripheral address register cleared at reset.
// - Every channel has a 10-bit count in a 16-bit register, upper bits zero; a block is count plus one.
// - A peripheral write collision on a channel sets its flag at bits 15..8.
// - A DMA RAM write collision on a channel sets its flag at bits 7..0.
// - Last-active-channel at bits 11..8 resets to 1111 and then holds the channel of each transfer.
// - A read-only ping-pong bit per channel reads one when the secondary start address is selected.
// - A 16-bit read-only register holds the DMA RAM address of the most recent access.
// - Bits 15..12 of the activity status register read as zero.
// - In ping-pong mode a channel alternates start addresses on successive blocks.
// - A channel is active while its enable bit is set.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_top (
    // Clock, reset, enable
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    input  wire logic                  CLK_EN,
    // AHB-Lite slave
    input  wire logic                  HSEL,
    input  wire logic [11:0]           HADDR,
    input  wire logic [1:0]            HTRANS,
    input  wire logic                  HWRITE,
    input  wire logic [2:0]            HSIZE,
    input  wire logic [31:0]           HWDATA,
    input  wire logic                  HREADY,
    output logic      [31:0]           HRDATA,
    output logic                       HREADYOUT,
    output logic                       HRESP,
    // Transfer engine events
    input  wire logic                  XFER_DONE,
    input  wire dcs_pkg::dcs_chan_id_t XFER_CHAN,
    input  wire dcs_pkg::dcs_half_t    XFER_RAM_ADDR,
    input  wire logic                  BLOCK_DONE,
    input  wire dcs_pkg::dcs_chan_vec_t PINGPONG_MODE,
    input  wire dcs_pkg::dcs_chan_vec_t PERIPH_COLLISION,
    input  wire dcs_pkg::dcs_chan_vec_t RAM_COLLISION,
    // Configuration to the engine
    output dcs_pkg::dcs_chan_vec_t     CHAN_ACTIVE,
    output dcs_pkg::dcs_chan_vec_t     PINGPONG_SEL,
    output logic [8*16-1:0]            CHAN_PERIPH_ADDR,
    output logic [8*10-1:0]            CHAN_XFER_COUNT,
    // Interrupt
    output logic                       IRQ
);
    import dcs_pkg::*;

    localparam int NCH = 8;
    initial begin
        if (NCH != `DCS_NUM_CHAN) $error("dcs_top supports exactly eight channels");
    end

    dcs_state_t s;
    dcs_state_t next_s;

    logic       addr_phase;
    logic [2:0] idx;
    logic [31:0] rd_mux;
    logic [2:0] events;
    logic       clr_stat;
    logic [11:0] a;
    logic [11:0] ra;
    logic [2:0] rd_idx;

    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign a = s.addr;
    assign idx = a[4:2];
    assign ra = {HADDR[11:2], 2'b00};
    assign rd_idx = HADDR[4:2];
    assign events = {|PERIPH_COLLISION | |RAM_COLLISION, XFER_DONE, BLOCK_DONE};

    // Next-state logic: bus phases, register writes, hardware updates
    always_comb begin
        next_s = s;
        rd_mux = 32'h0000_0000;
        clr_stat = 1'b0;
        // Hardware events
        if (XFER_DONE) begin
            next_s.last_chan = {1'b0, XFER_CHAN};
            next_s.ram_addr = XFER_RAM_ADDR;
        end
        if (BLOCK_DONE && PINGPONG_MODE[XFER_CHAN] && s.chan_en[XFER_CHAN]) begin
            next_s.pp_sel[XFER_CHAN] = ~s.pp_sel[XFER_CHAN];
        end
        // Data phase completes in the cycle after the address phase
        if (s.phase == DCS_DATA) begin
            next_s.phase = DCS_IDLE;
            if (s.wr) begin
                if (a == `DCS_OFF_COLL) begin
                    next_s.periph_write_collision = s.periph_write_collision & HWDATA[15:8];
                    next_s.ram_write_collision = s.ram_write_collision & HWDATA[7:0];
                end else if (a == `DCS_OFF_IRQ_MASK) begin
                    next_s.irq_mask = HWDATA[2:0];
                end else if (a == `DCS_OFF_CHAN_EN) begin
                    next_s.chan_en = HWDATA[7:0];
                end else if (a[11:5] == 7'(`DCS_OFF_PAD_BASE >> 5)) begin
                    next_s.pad[idx] = HWDATA[15:0];
                end else if (a[11:5] == 7'(`DCS_OFF_CNT_BASE >> 5)) begin
                    next_s.cnt[idx] = HWDATA[9:0];
                end
            end
        end
        // Hardware set wins over any software write clear
        next_s.periph_write_collision = next_s.periph_write_collision | PERIPH_COLLISION;
        next_s.ram_write_collision = next_s.ram_write_collision | RAM_COLLISION;
        next_s.irq_stat = next_s.irq_stat | events;
        // New address phase; read data taken from the updated state so it stands in the data phase
        if (addr_phase) begin
            next_s.phase = DCS_DATA;
            next_s.wr = HWRITE;
            next_s.addr = ra;
            if (!HWRITE) begin
                if (ra == `DCS_OFF_COLL) begin
                    rd_mux[15:0] = {next_s.periph_write_collision, next_s.ram_write_collision};
                end else if (ra == `DCS_OFF_ACT) begin
                    rd_mux[15:0] = {4'h0, next_s.last_chan, next_s.pp_sel};
                end else if (ra == `DCS_OFF_RAMADDR) begin
                    rd_mux[15:0] = next_s.ram_addr;
                end else if (ra == `DCS_OFF_IRQ_STAT) begin
                    rd_mux[2:0] = next_s.irq_stat;
                    clr_stat = 1'b1;
                end else if (ra == `DCS_OFF_IRQ_MASK) begin
                    rd_mux[2:0] = next_s.irq_mask;
                end else if (ra == `DCS_OFF_CHAN_EN) begin
                    rd_mux[7:0] = next_s.chan_en;
                end else if (ra[11:5] == 7'(`DCS_OFF_PAD_BASE >> 5)) begin
                    rd_mux[15:0] = next_s.pad[rd_idx];
                end else if (ra[11:5] == 7'(`DCS_OFF_CNT_BASE >> 5)) begin
                    rd_mux[9:0] = next_s.cnt[rd_idx];
                end
                next_s.rdata = rd_mux;
                // Events of this cycle are in the returned word, so clearing loses none
                if (clr_stat) begin
                    next_s.irq_stat = 3'h0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.last_chan <= `DCS_LAST_RESET;
        end else if (CLK_EN) begin
            s <= next_s;
        end
    end

    // Outputs
    assign HRDATA = s.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign CHAN_ACTIVE = s.chan_en;
    assign PINGPONG_SEL = s.pp_sel;
    assign CHAN_PERIPH_ADDR = s.pad;
    assign CHAN_XFER_COUNT = s.cnt;
    assign IRQ = |(s.irq_stat & s.irq_mask);
endmodule // dcs_top
